// file: rtl/stk_timer.sv
// System tick down counter with a classic Wishbone register slave
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// RL1 - Flag bit 16 sets whenever counter reached zero since last read.
// RL2 - Any read of control/status clears the flag after returning it.
// RL3 - Bit 2 picks counting clock: 0 crystal reference, 1 CPU clock.
// RL4 - Bit 1 set makes reaching zero pend the tick exception.
// RL5 - Setting bit 0 loads reload value and starts; clearing it stops.
// RL6 - Reload field, 24 bits, copied into counter whenever it reaches zero.
// RL7 - Reference clock is crystal input divided by 32.
// RL8 - Registers decode at 0x10, 0x14, 0x18, 0x1C, 0x20 and 0x24.
// RL9 - Any write to current value clears counter and zero-reached flag.
// RL10 - Calibration register reads 0x9C4, the 10 ms reload value.
// RL11 - Counter decrements per selected tick; reloads on tick after zero.
// RL12 - Unused control/status and reload bits read zero, writes ignored.

module stk_timer
  import stk_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic crystal_input_pin_i,
  output logic tick_exception_o,
  output logic irq_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic adr_hit(input logic [7:0] adr,
                                   input logic [7:0] ofs);
    adr_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    byte_merge = res;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  stk_state_type s_q;
  stk_state_type s_d;
  logic req;
  logic wr;
  logic rd;
  logic xtal_rise;
  logic ref_tick;
  logic tick;
  logic zero_hit;
  logic [31:0] csr_word;
  logic [31:0] rld_word;
  logic [31:0] wr_word;
  logic [31:0] rd_word;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.pend = 1'b0;
    zero_hit = 1'b0;
    wr_word = STK_WORD_ZERO;

    // Bus request taken once; ack follows in the next cycle
    req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = req & wb_we_i;
    rd = req & ~wb_we_i;
    s_d.ack = req;

    // Register images with unused bits at zero
    csr_word = STK_WORD_ZERO;
    csr_word[STK_ENABLE_BIT] = s_q.enable; // RL12
    csr_word[STK_PEND_BIT] = s_q.pend_en;
    csr_word[STK_CLKSEL_BIT] = s_q.clk_sel;
    csr_word[STK_FLAG_BIT] = s_q.flag;
    rld_word = STK_WORD_ZERO;
    rld_word[STK_CNT_W-1:0] = s_q.reload; // RL12

    // Crystal edges divided down to the reference tick
    s_d.xtal_q = crystal_input_pin_i;
    xtal_rise = crystal_input_pin_i & ~s_q.xtal_q;
    ref_tick = xtal_rise && (s_q.div == STK_DIV_LAST); // RL7
    if (xtal_rise)
    begin
      s_d.div = s_q.div + STK_DIV_ONE; // RL7
    end
    tick = s_q.clk_sel ? 1'b1 : ref_tick; // RL3

    // Down counting
    if (s_q.enable && tick)
    begin
      if (s_q.current == STK_CNT_ZERO)
      begin
        s_d.current = s_q.reload; // RL6 RL11
      end
      else
      begin
        s_d.current = s_q.current - STK_CNT_ONE; // RL11
        zero_hit = (s_q.current == STK_CNT_ONE);
      end
    end

    // Read data
    rd_word = STK_WORD_ZERO;
    if (adr_hit(wb_adr_i, STK_CSR_OFS)) // RL8
    begin
      rd_word = csr_word;
    end
    else if (adr_hit(wb_adr_i, STK_RLD_OFS))
    begin
      rd_word = rld_word;
    end
    else if (adr_hit(wb_adr_i, STK_CUR_OFS))
    begin
      rd_word[STK_CNT_W-1:0] = s_q.current;
    end
    else if (adr_hit(wb_adr_i, STK_CAL_OFS))
    begin
      rd_word = STK_CAL_VALUE; // RL10
    end
    else if (adr_hit(wb_adr_i, STK_IRQ_STS_OFS))
    begin
      rd_word[STK_IRQ_ZERO_BIT] = s_q.irq_sts;
    end
    else if (adr_hit(wb_adr_i, STK_IRQ_MSK_OFS))
    begin
      rd_word[STK_IRQ_ZERO_BIT] = s_q.irq_msk;
    end
    if (rd)
    begin
      s_d.dat = rd_word;
      if (adr_hit(wb_adr_i, STK_CSR_OFS))
      begin
        s_d.flag = 1'b0; // RL2
      end
    end

    // Register writes
    if (wr)
    begin
      if (adr_hit(wb_adr_i, STK_CSR_OFS))
      begin
        wr_word = byte_merge(csr_word, wb_dat_i, wb_sel_i);
        s_d.enable = wr_word[STK_ENABLE_BIT]; // RL5
        s_d.pend_en = wr_word[STK_PEND_BIT]; // RL4
        s_d.clk_sel = wr_word[STK_CLKSEL_BIT]; // RL3
        if (wr_word[STK_ENABLE_BIT] && !s_q.enable)
        begin
          s_d.current = s_q.reload; // RL5
          s_d.div = STK_DIV_ZERO;
          zero_hit = 1'b0;
        end
      end
      else if (adr_hit(wb_adr_i, STK_RLD_OFS))
      begin
        wr_word = byte_merge(rld_word, wb_dat_i, wb_sel_i);
        s_d.reload = wr_word[STK_CNT_W-1:0]; // RL6 RL12
      end
      else if (adr_hit(wb_adr_i, STK_CUR_OFS))
      begin
        s_d.current = STK_CNT_ZERO; // RL9
        s_d.flag = 1'b0; // RL9
        zero_hit = 1'b0;
      end
      else if (adr_hit(wb_adr_i, STK_IRQ_STS_OFS))
      begin
        if (wb_sel_i[0] && wb_dat_i[STK_IRQ_ZERO_BIT])
        begin
          s_d.irq_sts = 1'b0;
        end
      end
      else if (adr_hit(wb_adr_i, STK_IRQ_MSK_OFS))
      begin
        if (wb_sel_i[0])
        begin
          s_d.irq_msk = wb_dat_i[STK_IRQ_ZERO_BIT];
        end
      end
    end

    // Zero reached: a set beats a read or status-write clear in the same cycle; a current-value write cancels the set
    if (zero_hit)
    begin
      s_d.flag = 1'b1; // RL1
      s_d.irq_sts = 1'b1;
      s_d.pend = s_q.pend_en; // RL4
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= STK_STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign tick_exception_o = s_q.pend;
  assign irq_o = s_q.irq_sts & s_q.irq_msk;

endmodule // stk_timer

// file: rtl/stk_pkg.sv
// Constants and state type of the system tick down counter
package stk_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] STK_CSR_OFS = 8'h10;
  localparam logic [7:0] STK_RLD_OFS = 8'h14;
  localparam logic [7:0] STK_CUR_OFS = 8'h18;
  localparam logic [7:0] STK_CAL_OFS = 8'h1C;
  localparam logic [7:0] STK_IRQ_STS_OFS = 8'h20;
  localparam logic [7:0] STK_IRQ_MSK_OFS = 8'h24;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STK_ENABLE_BIT = 0;
  localparam int STK_PEND_BIT = 1;
  localparam int STK_CLKSEL_BIT = 2;
  localparam int STK_FLAG_BIT = 16;
  localparam int STK_IRQ_ZERO_BIT = 0;
  localparam int STK_CNT_W = 24;

  // ****************************************************************
  // Reset and constant values
  // ****************************************************************
  localparam logic [31:0] STK_WORD_ZERO = 32'h0000_0000;
  localparam logic [23:0] STK_CNT_ZERO = 24'h00_0000;
  localparam logic [23:0] STK_CNT_ONE = 24'h00_0001;
  // Reload for 10 ms at an 8 MHz crystal; reference present, no skew
  localparam logic [31:0] STK_CAL_VALUE = 32'h0000_09C4;

  // ****************************************************************
  // Crystal divider
  // ****************************************************************
  localparam int STK_XTAL_DIV = 32;
  localparam int STK_DIV_W = $clog2(STK_XTAL_DIV);
  localparam logic [STK_DIV_W-1:0] STK_DIV_ONE = 5'h01;
  localparam logic [STK_DIV_W-1:0] STK_DIV_LAST = 5'h1F;
  localparam logic [STK_DIV_W-1:0] STK_DIV_ZERO = 5'h00;

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic pend_en;
    logic clk_sel;
    logic flag;
    logic [STK_CNT_W-1:0] reload;
    logic [STK_CNT_W-1:0] current;
    logic [STK_DIV_W-1:0] div;
    logic xtal_q;
    logic irq_sts;
    logic irq_msk;
    logic ack;
    logic [31:0] dat;
    logic pend;
  } stk_state_type;

  localparam stk_state_type STK_STATE_RESET = '{
    enable: 1'b0,
    pend_en: 1'b0,
    clk_sel: 1'b0,
    flag: 1'b0,
    reload: 24'h00_0000,
    current: 24'h00_0000,
    div: 5'h00,
    xtal_q: 1'b0,
    irq_sts: 1'b0,
    irq_msk: 1'b0,
    ack: 1'b0,
    dat: 32'h0000_0000,
    pend: 1'b0
  };

endpackage

// file: test/stk_timer_chk.sv
// Port assertions for the system tick down counter
`timescale 1ns/1ps
module stk_timer_chk
  import stk_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tick_exception_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence rd_s(a);
    req_s ##0 (!wb_we_i && wb_adr_i == a);
  endsequence
  sequence unmap_s;
    req_s ##0 (!wb_we_i && (wb_adr_i < 8'h10 || wb_adr_i > 8'h27));
  endsequence
  AST_ACK_TAKE: assert property (req_s |=> wb_ack_o)
    else $error("request not acknowledged");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_IDLE: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without request");
  AST_CAL: assert property (rd_s(8'h1C) |=> wb_dat_o == 32'h0000_09C4)
    else $error("calibration value wrong");
  AST_CSR_RSV: assert property (rd_s(8'h10) |=>
    wb_dat_o[31:17] == 15'h0000 && wb_dat_o[15:3] == 13'h0000)
    else $error("control unused bits not zero");
  AST_RLD_RSV: assert property (rd_s(8'h14) |=>
    wb_dat_o[31:24] == 8'h00)
    else $error("reload upper bits not zero");
  AST_UNMAP: assert property (unmap_s |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_EXC_PULSE: assert property (tick_exception_o |=>
    !tick_exception_o)
    else $error("exception pulse too long");
endmodule // stk_timer_chk

bind stk_timer stk_timer_chk chk_i (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .tick_exception_o(tick_exception_o)
);

// file: test/stk_timer_tb.sv
// Self-checking bench for the system tick down counter
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("wrong value at %0t: %s", $time, m); end end
module stk_timer_tb;
  import stk_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, xtal = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] bsel = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, v;
  logic wb_ack_o, tick_exception_o, irq_o;
  logic [1:0] xc = 2'h0;
  int fails = 0, total_checks = 0, cycles = 0, n;
  stk_timer uut (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .crystal_input_pin_i(xtal),
    .tick_exception_o(tick_exception_o),
    .irq_o(irq_o)
  );
  always #5 sys_clk_i = ~sys_clk_i;
  // Crystal runs at a quarter of the system clock; hang guard
  always @(posedge sys_clk_i)
  begin
    xc <= xc + 2'h1;
    xtal <= xc[1];
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
      {2'b11, w, a, bsel, d};
    do
      @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_sel_i} <= 6'h00;
  endtask
  // Cycles from one exception pulse to the next
  task automatic gap(output int p);
    while (tick_exception_o !== 1'b1)
      @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    p = 1;
    while (tick_exception_o !== 1'b1)
    begin
      @(posedge sys_clk_i);
      p++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_regs();
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0000, "control reset")
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    bus(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h00FF_FFFF, "reload width")
    bsel = 4'h2;
    bus(1'b1, 8'h14, 32'h0000_0000);
    bsel = 4'hF;
    bus(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h00FF_00FF, "reload byte select")
    bus(1'b1, 8'h10, 32'hFFFF_FFF8);
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0000, "control unused")
    bus(1'b0, 8'h1C, 32'h0);
    `CHK(rd, 32'h0000_09C4, "calibration")
    bus(1'b0, 8'h2C, 32'h0);
    `CHK(rd, 32'h0000_0000, "unmapped")
  endtask
  task automatic t_cpu();
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h10, 32'h7);
    gap(n);
    `CHK(n, 4, "cpu clock period")
    `CHK(irq_o, 1'b0, "masked irq")
    bus(1'b1, 8'h24, 32'h1);
    `CHK(irq_o, 1'b1, "unmasked irq")
    bus(1'b1, 8'h10, 32'h6);
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0001_0006, "flag set")
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0006, "flag cleared by read")
    bus(1'b1, 8'h20, 32'h1);
    `CHK(irq_o, 1'b0, "irq cleared")
  endtask
  task automatic t_cur();
    n = 0;
    bus(1'b1, 8'h10, 32'h5);
    repeat (20)
    begin
      @(posedge sys_clk_i);
      n += (tick_exception_o === 1'b1);
    end
    `CHK(n, 0, "no pend when disabled")
    bus(1'b1, 8'h10, 32'h4);
    bus(1'b0, 8'h18, 32'h0);
    v = rd;
    repeat (5) @(posedge sys_clk_i);
    bus(1'b0, 8'h18, 32'h0);
    `CHK(rd, v, "stopped counter")
    bus(1'b1, 8'h18, 32'h123);
    bus(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0000_0000, "current cleared")
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0004, "flag cleared by write")
  endtask
  task automatic t_xtal();
    bus(1'b1, 8'h14, 32'h1);
    bus(1'b1, 8'h10, 32'h3);
    gap(n);
    `CHK(n, 256, "reference clock period")
    bus(1'b1, 8'h10, 32'h0);
  endtask
  // Reset in mid-run while the counter pends on the CPU clock
  task automatic t_rst();
    bus(1'b1, 8'h10, 32'h7);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    n = 0;
    repeat (10)
    begin
      @(posedge sys_clk_i);
      n += (tick_exception_o === 1'b1);
    end
    `CHK(n, 0, "no pend after reset")
    bus(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0000, "control after reset")
    bus(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0000_0000, "reload after reset")
    bus(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0000_0000, "current after reset")
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    $display("registers test done");
    t_cpu();
    $display("cpu clock test done");
    t_cur();
    $display("current value test done");
    t_xtal();
    $display("reference clock test done");
    t_rst();
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule // stk_timer_tb
